// ===== core/swp_pkg.sv
package swp_pkg;

  // register bus
  localparam int             ADDR_W       = 3;
  localparam int             DATA_W       = 32;
  localparam int             DUR_W        = 16;
  localparam logic [2:0]     ADDR_CFG     = 3'h0;
  localparam logic [2:0]     ADDR_T_CLOSE = 3'h1;
  localparam logic [2:0]     ADDR_T_OPEN  = 3'h2;
  localparam logic [2:0]     ADDR_T_SETTLE = 3'h3;
  localparam logic [2:0]     ADDR_TICK    = 3'h4;
  localparam logic [2:0]     ADDR_STATUS  = 3'h5;

  // config fields
  localparam int             CFG_MODE_LSB = 0;
  localparam int             CFG_CA_BIT   = 2;
  localparam int             CFG_OA_BIT   = 3;
  localparam logic [3:0]     RST_CFG      = 4'hc;

  // durations in ticks after reset
  localparam logic [15:0]    RST_T_CLOSE  = 16'h0064;
  localparam logic [15:0]    RST_T_OPEN   = 16'h0064;
  localparam logic [15:0]    RST_T_SETTLE = 16'h0000;

  // time base: one tick per millisecond at 25 MHz
  localparam int             CLK_NS       = 40;
  localparam int             TICK_NS      = 1000000;
  localparam int             TICK_CYC     = TICK_NS / CLK_NS;

  // position codes
  localparam logic [1:0]     POS_INDET    = 2'h0;
  localparam logic [1:0]     POS_OPEN     = 2'h1;
  localparam logic [1:0]     POS_CLOSED   = 2'h2;
  localparam logic [1:0]     POS_DISTURB  = 2'h3;

  typedef enum logic [1:0] {
    PH_IDLE   = 2'b00,
    PH_CLOSE  = 2'b01,
    PH_OPEN   = 2'b10,
    PH_SETTLE = 2'b11
  } swp_phase_t;

  typedef enum logic [1:0] {
    MODE_TWO   = 2'b00,
    MODE_CLOSE = 2'b01,
    MODE_OPEN  = 2'b10,
    MODE_BAD   = 2'b11
  } swp_mode_t;

  typedef struct packed {
    logic close_side;
    logic open_side;
  } swp_aux_t;

  typedef struct packed {
    logic close;
    logic open;
  } swp_cmd_t;

  typedef struct packed {
    logic       switch_success_flag;
    logic       one_contact_flag;
    logic       fault;
    logic       moving;
    logic       opened;
    logic       closed;
    logic [1:0] code;
  } swp_pos_t;

endpackage : swp_pkg

// ===== core/swp_tick.sv
`timescale 1ns/1ps
module swp_tick (
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic [15:0] period,
  input  wire logic        restart,
  output logic             tick
);
  import swp_pkg::*;

  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
  } swp_tick_st_t;

  swp_tick_st_t s_reg;
  swp_tick_st_t s_next;

  // restart aligns the first tick to a full period after a start
  always_comb begin
    s_next      = s_reg;
    s_next.tick = 1'b0;
    if (restart || s_reg.cnt == 16'h0000) begin
      s_next.cnt = (period == 16'h0000) ? 16'h0000 : period - 16'h0001;
    end else begin
      s_next.cnt = s_reg.cnt - 16'h0001;
    end
    if (!restart && s_reg.cnt == 16'h0000) begin
      s_next.tick = 1'b1;
    end
    if (!rst_b) begin
      s_next = '0;
    end
  end

  always_ff @(posedge core_clk) begin
    s_reg <= s_next;
  end

  assign tick = s_reg.tick;

endmodule : swp_tick

// ===== core/swp_timer.sv
`timescale 1ns/1ps
module swp_timer #(
  parameter int W = swp_pkg::DUR_W
) (
  input  wire logic         core_clk,
  input  wire logic         rst_b,
  input  wire logic         start,
  input  wire logic         stop,
  input  wire logic [W-1:0] dur,
  input  wire logic         tick,
  output logic              expired
);
  import swp_pkg::*;

  if (W < 2) begin : g_chk
    $error("swp_timer: W must be at least 2");
  end

  typedef struct packed {
    logic         run;
    logic         exp;
    logic [W-1:0] cnt;
  } swp_tmr_st_t;

  swp_tmr_st_t s_reg;
  swp_tmr_st_t s_next;

  // zero duration expires on the cycle after start
  always_comb begin
    s_next     = s_reg;
    s_next.exp = 1'b0;
    if (stop) begin
      s_next.run = 1'b0;
    end else if (start) begin
      s_next.run = (dur != '0);
      s_next.exp = (dur == '0);
      s_next.cnt = dur;
    end else if (s_reg.run && tick) begin
      if (s_reg.cnt == W'(1)) begin
        s_next.run = 1'b0;
        s_next.exp = 1'b1;
      end else begin
        s_next.cnt = s_reg.cnt - W'(1);
      end
    end
    if (!rst_b) begin
      s_next = '0;
    end
  end

  always_ff @(posedge core_clk) begin
    s_reg <= s_next;
  end

  assign expired = s_reg.exp;

endmodule : swp_timer

// ===== core/swp_supervisor.sv
// The address map and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
// Summary of operation
// - sample both contacts every cycle
// - position code: 0 indet,1 open,2 closed,3 disturbed
// - close command starts close travel timer
// - open command starts open travel timer
// - supervised travel shows moving, code 0, no fault
// - commanded end before expiry gives position
// - expiry without end position gives fault, code 3, unless a single-contact settle delay is set
// - two contacts: 10 closed code 2, 01 open 1
// - two contacts idle and equal: fault, code 3
// - single contact configured raises one-contact flag
// - single contact supervises one direction only
// - close-only: arrival gives closed and success
// - close-only: expiry with zero settle time gives fault, clears moving
// - close-only: settle delay after travel, moving
// - close-only: settle end shows closed
// - close-only: high gives 2, low idle 1
// - unassigned required contact holds code 3
// - drive ends at travel time or arrival
module swp_supervisor #(
  parameter int TICK_CYCLES = swp_pkg::TICK_CYC
) (
  input  wire logic                     core_clk,
  input  wire logic                     rst_b,
  input  wire logic [swp_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [swp_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic [swp_pkg::DATA_W-1:0]    reg_rdata,
  input  wire swp_pkg::swp_aux_t        aux,
  input  wire swp_pkg::swp_cmd_t        cmd,
  output swp_pkg::swp_pos_t             pos,
  output logic                          drive_close,
  output logic                          drive_open
);
  import swp_pkg::*;

  if (TICK_CYCLES < 1 || TICK_CYCLES > 65535) begin : g_chk
    $error("swp_supervisor: TICK_CYCLES out of range");
  end

  typedef struct packed {
    swp_phase_t  phase;
    logic        sup;
    logic        fault_hold;
    logic        settled;
    logic        success;
    swp_mode_t   mode;
    logic        close_asg;
    logic        open_asg;
    logic [15:0] t_close;
    logic [15:0] t_open;
    logic [15:0] t_settle;
    logic [15:0] tick_per;
    swp_pos_t    pos;
    logic [31:0] rdata;
  } swp_st_t;

  swp_st_t     s_reg;
  swp_st_t     s_next;
  logic        tick;
  logic        exp_cl;
  logic        exp_op;
  logic        exp_st;
  logic        start_cl;
  logic        start_op;
  logic        start_st;
  logic        stop_cl;
  logic        stop_op;
  logic        stop_st;

  // decoded view of wiring and contacts, from registered config
  logic        two;
  logic        cl_only;
  logic        op_only;
  logic        unassigned;
  logic        closed_in;
  logic        open_in;
  logic        go_open;
  logic        go_close;
  logic        moving_now;

  ////////////////////////////////////////////////////////////////////
  // contact decode

  always_comb begin
    two        = (s_reg.mode == MODE_TWO);
    cl_only    = (s_reg.mode == MODE_CLOSE);
    op_only    = (s_reg.mode == MODE_OPEN);
    unassigned = (two && !(s_reg.close_asg && s_reg.open_asg)) ||
                 (cl_only && !s_reg.close_asg) ||
                 (op_only && !s_reg.open_asg) ||
                 (s_reg.mode == MODE_BAD);
    if (two) begin
      closed_in = aux.close_side && !aux.open_side;
      open_in   = !aux.close_side && aux.open_side;
    end else if (cl_only) begin
      closed_in = aux.close_side;
      open_in   = !aux.close_side;
    end else begin
      closed_in = !aux.open_side;
      open_in   = aux.open_side;
    end
    // open wins over close; close is only taken when idle
    go_open  = cmd.open && s_reg.phase != PH_OPEN;
    go_close = cmd.close && !cmd.open && s_reg.phase == PH_IDLE;
  end

  ////////////////////////////////////////////////////////////////////
  // state update

  always_comb begin
    s_next       = s_reg;
    s_next.rdata = '0;
    start_cl     = 1'b0;
    start_op     = 1'b0;
    start_st     = 1'b0;
    stop_cl      = 1'b0;
    stop_op      = 1'b0;
    stop_st      = 1'b0;
    moving_now   = 1'b0;

    if (reg_wr) begin
      case (reg_addr)
        ADDR_CFG: begin
          s_next.mode      = swp_mode_t'(reg_wdata[CFG_MODE_LSB +: 2]);
          s_next.close_asg = reg_wdata[CFG_CA_BIT];
          s_next.open_asg  = reg_wdata[CFG_OA_BIT];
          // a settled end seen under the old wiring no longer applies
          s_next.settled   = 1'b0;
        end
        ADDR_T_CLOSE:  s_next.t_close  = reg_wdata[15:0];
        ADDR_T_OPEN:   s_next.t_open   = reg_wdata[15:0];
        ADDR_T_SETTLE: s_next.t_settle = reg_wdata[15:0];
        ADDR_TICK:     s_next.tick_per = reg_wdata[15:0];
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        ADDR_CFG: s_next.rdata = {28'h0, s_reg.open_asg, s_reg.close_asg,
                                  s_reg.mode};
        ADDR_T_CLOSE:  s_next.rdata = {16'h0, s_reg.t_close};
        ADDR_T_OPEN:   s_next.rdata = {16'h0, s_reg.t_open};
        ADDR_T_SETTLE: s_next.rdata = {16'h0, s_reg.t_settle};
        ADDR_TICK:     s_next.rdata = {16'h0, s_reg.tick_per};
        ADDR_STATUS:   s_next.rdata = {22'h0, s_reg.phase, s_reg.pos};
        default:       s_next.rdata = '0;
      endcase
    end

    case (s_reg.phase)
      PH_CLOSE: begin
        if (closed_in) begin
          s_next.phase   = PH_IDLE;
          s_next.success = s_reg.sup;
          stop_cl        = 1'b1;
        end else if (exp_cl) begin
          s_next.phase = PH_IDLE;
          if (s_reg.sup && cl_only && s_reg.t_settle != '0) begin
            s_next.phase = PH_SETTLE;
            start_st     = 1'b1;
          end else if (s_reg.sup) begin
            s_next.fault_hold = 1'b1;
          end
        end
      end
      PH_OPEN: begin
        if (open_in) begin
          s_next.phase   = PH_IDLE;
          s_next.success = s_reg.sup;
          stop_op        = 1'b1;
        end else if (exp_op) begin
          s_next.phase = PH_IDLE;
          if (s_reg.sup && op_only && s_reg.t_settle != '0) begin
            s_next.phase = PH_SETTLE;
            start_st     = 1'b1;
          end else if (s_reg.sup) begin
            s_next.fault_hold = 1'b1;
          end
        end
      end
      PH_SETTLE: begin
        if (exp_st) begin
          s_next.phase   = PH_IDLE;
          s_next.settled = 1'b1;
        end
      end
      default: ;
    endcase

    // a new command drops any earlier outcome
    if (go_open) begin
      s_next.phase      = PH_OPEN;
      s_next.sup        = two || op_only;
      s_next.fault_hold = 1'b0;
      s_next.settled    = 1'b0;
      s_next.success    = 1'b0;
      start_op          = 1'b1;
      stop_cl           = 1'b1;
      stop_st           = 1'b1;
    end else if (go_close) begin
      s_next.phase      = PH_CLOSE;
      s_next.sup        = two || cl_only;
      s_next.fault_hold = 1'b0;
      s_next.settled    = 1'b0;
      s_next.success    = 1'b0;
      start_cl          = 1'b1;
    end

    // outputs follow the next state; unsupervised travel is not moving
    moving_now = (s_next.phase == PH_SETTLE) ||
                 ((s_next.phase != PH_IDLE) && s_next.sup);
    s_next.pos = '0;
    if (unassigned) begin
      s_next.pos.code = POS_DISTURB;
    end else if (s_next.fault_hold) begin
      s_next.pos.code = POS_DISTURB;
    end else if (s_next.settled) begin
      s_next.pos.code = cl_only ? POS_CLOSED : POS_OPEN;
    end else if (moving_now) begin
      s_next.pos.code   = POS_INDET;
      s_next.pos.moving = 1'b1;
    end else if (closed_in) begin
      s_next.pos.code = POS_CLOSED;
    end else if (open_in) begin
      s_next.pos.code = POS_OPEN;
    end else begin
      s_next.pos.code = POS_DISTURB;
    end
    s_next.pos.closed = (s_next.pos.code == POS_CLOSED);
    s_next.pos.opened = (s_next.pos.code == POS_OPEN);
    s_next.pos.fault  = (s_next.pos.code == POS_DISTURB);
    s_next.pos.one_contact_flag    = cl_only || op_only;
    s_next.pos.switch_success_flag = s_next.success;

    if (!rst_b) begin
      s_next          = '0;
      s_next.mode     = swp_mode_t'(RST_CFG[CFG_MODE_LSB +: 2]);
      s_next.close_asg = RST_CFG[CFG_CA_BIT];
      s_next.open_asg = RST_CFG[CFG_OA_BIT];
      s_next.t_close  = RST_T_CLOSE;
      s_next.t_open   = RST_T_OPEN;
      s_next.t_settle = RST_T_SETTLE;
      s_next.tick_per = 16'(TICK_CYCLES);
    end
  end

  always_ff @(posedge core_clk) begin
    s_reg <= s_next;
  end

  assign reg_rdata   = s_reg.rdata;
  assign pos         = s_reg.pos;
  assign drive_close = (s_reg.phase == PH_CLOSE);
  assign drive_open  = (s_reg.phase == PH_OPEN);

  ////////////////////////////////////////////////////////////////////
  // shared time base and the three timers

  swp_tick u_tick (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .period   (s_reg.tick_per),
    .restart  (start_cl || start_op || start_st),
    .tick     (tick)
  );

  swp_timer #(.W(DUR_W)) u_close_tmr (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .start    (start_cl),
    .stop     (stop_cl),
    .dur      (s_reg.t_close),
    .tick     (tick),
    .expired  (exp_cl)
  );

  swp_timer #(.W(DUR_W)) u_open_tmr (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .start    (start_op),
    .stop     (stop_op),
    .dur      (s_reg.t_open),
    .tick     (tick),
    .expired  (exp_op)
  );

  swp_timer #(.W(DUR_W)) u_settle_tmr (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .start    (start_st),
    .stop     (stop_st),
    .dur      (s_reg.t_settle),
    .tick     (tick),
    .expired  (exp_st)
  );

  ////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  code_map_a: assert property (
    (pos.closed == (pos.code == POS_CLOSED)) &&
    (pos.opened == (pos.code == POS_OPEN)) &&
    (pos.fault == (pos.code == POS_DISTURB)))
    else $error("flags disagree with position code");

  close_start_a: assert property (
    go_close |=> drive_close && u_close_tmr.s_reg.run == (s_reg.t_close != '0))
    else $error("close command did not start travel");

  open_start_a: assert property (
    cmd.open && !drive_open |=> drive_open && !drive_close)
    else $error("open command did not start travel");

  moving_code_a: assert property (
    pos.moving |-> pos.code == POS_INDET && !pos.fault)
    else $error("moving with wrong code");

  arrive_end_a: assert property (
    drive_close && closed_in && !cmd.open && !unassigned && s_reg.sup
    |=> !drive_close ##0 pos.switch_success_flag ##0 !pos.moving)
    else $error("arrival not reported");

  expiry_fault_a: assert property (
    drive_close && exp_cl && !closed_in && two && !unassigned &&
    !cmd.open |=> pos.fault ##0 pos.code == POS_DISTURB ##0 !drive_close)
    else $error("expiry not reported as fault");

  equal_fault_a: assert property (
    two && !unassigned && s_reg.phase == PH_IDLE && !s_reg.fault_hold &&
    !cmd.open && !cmd.close && aux.close_side == aux.open_side
    |=> pos.code == POS_DISTURB)
    else $error("equal contacts not disturbed");

  one_contact_a: assert property (
    ##1 pos.one_contact_flag == $past(cl_only || op_only))
    else $error("one-contact flag wrong");

  settle_start_a: assert property (
    drive_close && exp_cl && !closed_in && cl_only && !unassigned &&
    s_reg.t_settle != '0 && !cmd.open
    |=> s_reg.phase == PH_SETTLE ##0 pos.moving)
    else $error("settle delay did not start");

  unassigned_a: assert property (
    unassigned && !reg_wr |=> pos.code == POS_DISTURB)
    else $error("unassigned contact not disturbed");

  close_cover_c: cover property (
    drive_close ##[1:1000] pos.switch_success_flag);
  fault_cover_c: cover property (
    drive_open ##1 exp_op ##1 pos.fault);
  settle_cover_c: cover property (
    s_reg.phase == PH_SETTLE ##[1:1000] s_reg.settled);

endmodule : swp_supervisor

// ===== testbench/swp_aux_model.sv
`timescale 1ns/1ps
module swp_aux_model (
  input  wire logic              core_clk,
  input  wire logic              drive_close,
  input  wire logic              drive_open,
  input  wire logic              stuck,
  input  wire logic              hold_en,
  input  wire swp_pkg::swp_aux_t hold_val,
  input  wire logic [7:0]        delay,
  output swp_pkg::swp_aux_t      aux
);
  import swp_pkg::*;

  swp_aux_t   state_reg = 2'b01;
  logic [7:0] cnt_reg   = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // contacts break first, then make after the lag; a jammed gear never moves
  always_ff @(posedge core_clk) begin
    if (!(drive_close || drive_open) || stuck) begin
      cnt_reg <= 8'h00;
    end else if (cnt_reg == delay) begin
      state_reg <= drive_open ? 2'b01 : 2'b10;
    end else begin
      if (cnt_reg == 8'h00) begin
        state_reg <= 2'b00;
      end
      cnt_reg <= cnt_reg + 8'h01;
    end
  end

  // bench may pin the contacts to exercise static combinations
  assign aux = hold_en ? hold_val : state_reg;
endmodule : swp_aux_model

// ===== testbench/swp_supervisor_bench.sv
`timescale 1ns/1ps
module swp_supervisor_bench;
  import swp_pkg::*;

  localparam int TCYC = 4;

  logic              core_clk;
  logic              rst_b;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic [DATA_W-1:0] reg_rdata;
  logic              reg_wr;
  logic              reg_rd;
  swp_aux_t          aux;
  swp_aux_t          hold_val;
  swp_cmd_t          cmd;
  swp_pos_t          pos;
  logic              drive_close;
  logic              drive_open;
  logic              stuck;
  logic              hold_en;
  logic [7:0]        delay;
  logic              rd_d;
  logic [1:0]        v;
  int                errors;
  int                n_tests;
  logic [31:0]       exp_q[$];
  logic [31:0]       msk_q[$];

  swp_supervisor #(.TICK_CYCLES(TCYC)) u_swp_supervisor (
    .core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .aux(aux), .cmd(cmd), .pos(pos),
    .drive_close(drive_close), .drive_open(drive_open)
  );

  swp_aux_model u_swp_aux_model (
    .core_clk(core_clk), .drive_close(drive_close),
    .drive_open(drive_open), .stuck(stuck), .hold_en(hold_en),
    .hold_val(hold_val), .delay(delay), .aux(aux)
  );

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task finish_test;
    if (errors == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test

  task cmp_rd(input logic [31:0] got, input logic [31:0] e,
              input logic [31:0] m);
    n_tests++;
    if ((got & m) !== (e & m)) begin
      errors++;
      $display("unexpected t=%0t got %h exp %h", $time, got & m, e & m);
    end
  endtask : cmp_rd

  task wr(input logic [2:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask : wr

  // expectation is noted before the strobe; the monitor pops it later
  task rd(input logic [2:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
  endtask : rd

  task go(input logic cls, input logic stk, input logic [7:0] lag);
    stuck     <= stk;
    delay     <= lag;
    @(posedge core_clk);
    cmd.close <= cls;
    cmd.open  <= ~cls;
    @(posedge core_clk);
    cmd       <= 2'b00;
  endtask : go

  // drive must fall within travel time plus two cycles of latency
  task settle(input int n);
    int i;
    for (i = 0; i < n; i++) begin
      @(posedge core_clk);
      #1;
      if (!(drive_close || drive_open)) break;
    end
    if (drive_close || drive_open) begin
      errors++;
      $display("unexpected t=%0t drive %h exp %h", $time,
               {drive_close, drive_open}, 2'h0);
      finish_test();
    end else begin
      @(posedge core_clk);
    end
  endtask : settle

  always @(posedge core_clk) begin
    rd_d <= reg_rd;
    if (rd_d && exp_q.size() > 0) begin
      cmp_rd(reg_rdata, exp_q.pop_front(), msk_q.pop_front());
    end
  end

  initial begin
    repeat (100000) @(posedge core_clk);
    errors++;
    finish_test();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_b     = 1'b0;
    reg_addr  = 3'h0;
    reg_wdata = 32'h0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    cmd       = 2'b00;
    stuck     = 1'b0;
    hold_en   = 1'b0;
    hold_val  = 2'b01;
    delay     = 8'h03;
    errors    = 0;
    n_tests   = 0;
    void'($urandom(32'h79e7));
    repeat (16) @(posedge core_clk);
    rst_b <= 1'b1;
    rd(ADDR_CFG, 32'hc, 32'hf);
    rd(ADDR_T_CLOSE, 32'h64, 32'hffff);
    rd(ADDR_T_SETTLE, 32'h0, 32'hffff);
    rd(ADDR_TICK, TCYC, 32'hffff);
    rd(3'h6, 32'h0, 32'hffffffff);
    rd(ADDR_STATUS, 32'h009, 32'h3ff);
    wr(ADDR_T_CLOSE, 32'h3);
    wr(ADDR_T_OPEN, 32'h3);
    wr(ADDR_STATUS, 32'hffffffff);
    rd(ADDR_STATUS, 32'h009, 32'h3ff);
    // close, contacts arrive early
    go(1'b1, 1'b0, 8'(2 + $urandom % 6));
    rd(ADDR_STATUS, 32'h110, 32'h3ff);
    settle(16);
    rd(ADDR_STATUS, 32'h086, 32'h3ff);
    // open, gear jammed
    go(1'b0, 1'b1, 8'h00);
    settle(14);
    rd(ADDR_STATUS, 32'h023, 32'h3ff);
    go(1'b0, 1'b0, 8'(2 + $urandom % 6));
    settle(16);
    rd(ADDR_STATUS, 32'h089, 32'h3ff);
    // static combinations with no timer running
    hold_en <= 1'b1;
    repeat (8) begin
      v = 2'($urandom % 4);
      hold_val <= v;
      repeat (2) @(posedge core_clk);
      rd(ADDR_STATUS, v == 2'b10 ? 32'h06 : v == 2'b01 ? 32'h09 : 32'h23,
         32'h7f);
    end
    hold_val <= 2'b01;
    @(posedge core_clk);
    hold_en  <= 1'b0;
    // close-side contact only
    wr(ADDR_CFG, 32'h5);
    repeat (2) @(posedge core_clk);
    rd(ADDR_STATUS, 32'h049, 32'h37f);
    go(1'b1, 1'b0, 8'h03);
    settle(16);
    rd(ADDR_STATUS, 32'h0c6, 32'h3ff);
    go(1'b0, 1'b0, 8'h04);
    rd(ADDR_STATUS, 32'h240, 32'h350);
    settle(16);
    rd(ADDR_STATUS, 32'h049, 32'h37f);
    go(1'b1, 1'b1, 8'h00);
    settle(14);
    rd(ADDR_STATUS, 32'h063, 32'h3ff);
    // settle delay of two ticks after an unanswered close
    wr(ADDR_T_SETTLE, 32'h2);
    go(1'b1, 1'b1, 8'h00);
    repeat (16) @(posedge core_clk);
    rd(ADDR_STATUS, 32'h350, 32'h3ff);
    repeat (20) @(posedge core_clk);
    rd(ADDR_STATUS, 32'h046, 32'h37f);
    // open-side contact only: open travel is the supervised one
    wr(ADDR_CFG, 32'ha);
    repeat (2) @(posedge core_clk);
    rd(ADDR_STATUS, 32'h046, 32'h37f);
    go(1'b0, 1'b0, 8'h03);
    rd(ADDR_STATUS, 32'h250, 32'h3ff);
    settle(16);
    rd(ADDR_STATUS, 32'h0c9, 32'h3ff);
    // required contact left unassigned, then an invalid mode
    wr(ADDR_CFG, 32'h1);
    repeat (2) @(posedge core_clk);
    rd(ADDR_STATUS, 32'h3, 32'h3);
    wr(ADDR_CFG, 32'hf);
    repeat (2) @(posedge core_clk);
    rd(ADDR_STATUS, 32'h3, 32'h3);
    repeat (4) @(posedge core_clk);
    finish_test();
  end
endmodule : swp_supervisor_bench
